// ---- hw/dcirm_matrix.sv ----
// Contract
// - Each core sees 32 lines, 26 peripheral.
// - Lines 6,7,11,15,16,29 are internal, never driven.
// - Only peripheral line numbers take routed sources.
// - Level lines carry their fixed priorities.
// - Edge lines 10,22,28,30; line 14 is NMI.
// - Each core has its own per-source route.
// - Peripheral line number in route drives that line.
// - Any internal line number detaches the source.
// - Sources sharing a line are ORed together.
// - NMI mask input blocks sources on line 14.
// - Status words show each source's live state.
// - Source n sits in word n/32, bit n%32.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`include "dcirm_params.svh"
`default_nettype none
module dcirm_matrix #(
    parameter int NUM_SRC = `DCIRM_NUM_SRC
) (
    // Clock, reset and freeze.
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // Register bus.
    input wire dcirm_pkg::dcirm_bus_req_type bus_req,
    output logic [31:0] rd_data,
    // Peripheral sources and NMI mask from the process-context controller.
    input wire logic [NUM_SRC-1:0] src_level,
    input wire logic [1:0] nmi_mask,
    // Core interrupt lines and the block's own interrupt.
    output logic [31:0] primary_core_lines,
    output logic [31:0] secondary_core_lines,
    output logic irq
);
    import dcirm_pkg::*;

    // Width of the status words taken together.
    localparam int STAT_BITS = `DCIRM_STAT_WORDS * 32;
    // Peripheral line mask as an indexable constant.
    localparam logic [31:0] PERIPH = `DCIRM_PERIPH_MASK;

    // Source count must fit the status words and the route region.
    if (NUM_SRC < 1 || NUM_SRC > STAT_BITS)
    begin : g_bad_num_src
        $error("NUM_SRC out of range for the status words");
    end

    // Routes of one core, one field per source.
    typedef logic [NUM_SRC-1:0][`DCIRM_ROUTE_W-1:0] dcirm_routes_type;

    // Whole state of the block.
    typedef struct packed {
        dcirm_routes_type [1:0] route;
        logic [1:0][31:0] lines;
        logic [`DCIRM_EVT_W-1:0] evt;
        logic [`DCIRM_EVT_W-1:0] evt_mask;
        logic [31:0] rd_data;
        logic irq;
    } dcirm_state_type;

    // Registered state and its next value.
    dcirm_state_type state_r;
    dcirm_state_type state_nxt;
    // Sources padded to whole status words.
    logic [STAT_BITS-1:0] src_wide;
    // Lines of each core before the NMI mask.
    logic [1:0][31:0] raw_lines;

    // Builds one core's lines from its routes, ORing shared lines.
    function automatic logic [31:0] route_lines(
        input dcirm_routes_type routes,
        input logic [NUM_SRC-1:0] src,
        input logic nmi_blk
    );
        logic [31:0] acc;
        acc = 32'h0000_0000;
        for (int s = 0; s < NUM_SRC; s++)
        begin
            acc[routes[s]] = acc[routes[s]] | src[s];
        end
        acc = acc & PERIPH;
        if (nmi_blk)
        begin
            acc[`DCIRM_NMI_LINE] = 1'b0;
        end
        return acc;
    endfunction : route_lines

    // True when the address hits a word of the region at base.
    function automatic logic word_hit(
        input logic [11:0] a,
        input logic [11:0] base,
        input int nwords
    );
        int off;
        off = int'(a) - int'(base);
        return (a[1:0] == 2'b00) && (off >= 0) && (off < 4 * nwords);
    endfunction : word_hit

    // Word index of the address within the region at base.
    function automatic logic [6:0] word_idx(
        input logic [11:0] a,
        input logic [11:0] base
    );
        logic [11:0] d;
        d = a - base;
        return d[8:2];
    endfunction : word_idx

    // Status words show the raw source levels, before any routing.
    assign src_wide = STAT_BITS'(src_level);

    // Unmasked lines, used to see that the NMI mask held a source back.
    assign raw_lines[0] = route_lines(state_r.route[0], src_level, 1'b0);
    assign raw_lines[1] = route_lines(state_r.route[1], src_level, 1'b0);

    // Next state: routing, events, register writes and reads.
    always_comb
    begin
        state_nxt = state_r;
        if (clk_en)
        begin
            // Read data stands for exactly one cycle after the strobe.
            state_nxt.rd_data = 32'h0000_0000;
            // Each core's lines come from its own routes only.
            for (int c = 0; c < 2; c++)
            begin
                state_nxt.lines[c] = route_lines(state_r.route[c],
                    src_level, nmi_mask[c]);
            end
            // Writes to routes, event clear and event mask.
            if (bus_req.wr)
            begin
                if (word_hit(bus_req.addr, `DCIRM_PRI_ROUTE_BASE, NUM_SRC))
                begin
                    state_nxt.route[0][word_idx(bus_req.addr,
                        `DCIRM_PRI_ROUTE_BASE)] =
                        bus_req.wdata[`DCIRM_ROUTE_W-1:0];
                end
                else if (word_hit(bus_req.addr, `DCIRM_SEC_ROUTE_BASE,
                    NUM_SRC))
                begin
                    state_nxt.route[1][word_idx(bus_req.addr,
                        `DCIRM_SEC_ROUTE_BASE)] =
                        bus_req.wdata[`DCIRM_ROUTE_W-1:0];
                end
                else if (bus_req.addr == `DCIRM_EVT_STAT_ADDR)
                begin
                    // Writing a one clears that event bit.
                    state_nxt.evt = state_r.evt &
                        ~bus_req.wdata[`DCIRM_EVT_W-1:0];
                end
                else if (bus_req.addr == `DCIRM_EVT_MASK_ADDR)
                begin
                    state_nxt.evt_mask = bus_req.wdata[`DCIRM_EVT_W-1:0];
                end
                else
                begin
                    // Unmapped writes are dropped.
                    state_nxt.evt_mask = state_r.evt_mask;
                end
            end
            // New events are applied after the clear, so a set wins.
            state_nxt.evt[`DCIRM_EVT_PRI_NMI_RISE] =
                state_nxt.evt[`DCIRM_EVT_PRI_NMI_RISE] |
                (state_nxt.lines[0][`DCIRM_NMI_LINE] &
                ~state_r.lines[0][`DCIRM_NMI_LINE]);
            state_nxt.evt[`DCIRM_EVT_SEC_NMI_RISE] =
                state_nxt.evt[`DCIRM_EVT_SEC_NMI_RISE] |
                (state_nxt.lines[1][`DCIRM_NMI_LINE] &
                ~state_r.lines[1][`DCIRM_NMI_LINE]);
            state_nxt.evt[`DCIRM_EVT_PRI_NMI_BLOCK] =
                state_nxt.evt[`DCIRM_EVT_PRI_NMI_BLOCK] |
                (nmi_mask[0] & raw_lines[0][`DCIRM_NMI_LINE]);
            state_nxt.evt[`DCIRM_EVT_SEC_NMI_BLOCK] =
                state_nxt.evt[`DCIRM_EVT_SEC_NMI_BLOCK] |
                (nmi_mask[1] & raw_lines[1][`DCIRM_NMI_LINE]);
            // Reads: answer in the next cycle, zero when unmapped.
            if (bus_req.rd)
            begin
                if (word_hit(bus_req.addr, `DCIRM_PRI_ROUTE_BASE, NUM_SRC))
                begin
                    state_nxt.rd_data = 32'(state_r.route[0][word_idx(
                        bus_req.addr, `DCIRM_PRI_ROUTE_BASE)]);
                end
                else if (word_hit(bus_req.addr, `DCIRM_SEC_ROUTE_BASE,
                    NUM_SRC))
                begin
                    state_nxt.rd_data = 32'(state_r.route[1][word_idx(
                        bus_req.addr, `DCIRM_SEC_ROUTE_BASE)]);
                end
                else if (word_hit(bus_req.addr, `DCIRM_PRI_STAT_BASE,
                    `DCIRM_STAT_WORDS))
                begin
                    state_nxt.rd_data = src_wide[32 * word_idx(
                        bus_req.addr, `DCIRM_PRI_STAT_BASE) +: 32];
                end
                else if (word_hit(bus_req.addr, `DCIRM_SEC_STAT_BASE,
                    `DCIRM_STAT_WORDS))
                begin
                    state_nxt.rd_data = src_wide[32 * word_idx(
                        bus_req.addr, `DCIRM_SEC_STAT_BASE) +: 32];
                end
                else if (bus_req.addr == `DCIRM_EVT_STAT_ADDR)
                begin
                    state_nxt.rd_data = 32'(state_r.evt);
                end
                else if (bus_req.addr == `DCIRM_EVT_MASK_ADDR)
                begin
                    state_nxt.rd_data = 32'(state_r.evt_mask);
                end
                else if (word_hit(bus_req.addr, `DCIRM_LINE_INFO_BASE, 32))
                begin
                    state_nxt.rd_data = 32'(dcirm_line_info(5'(word_idx(
                        bus_req.addr, `DCIRM_LINE_INFO_BASE))));
                end
                else
                begin
                    state_nxt.rd_data = 32'h0000_0000;
                end
            end
            // Level interrupt while any unmasked event bit is set.
            state_nxt.irq = |(state_nxt.evt & state_nxt.evt_mask);
        end
    end

    // State register; every route starts on an internal line.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r.route <= {(2 * NUM_SRC){`DCIRM_ROUTE_RST}};
            state_r.lines <= '0;
            state_r.evt <= '0;
            state_r.evt_mask <= `DCIRM_EVT_MASK_RST;
            state_r.rd_data <= 32'h0000_0000;
            state_r.irq <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign rd_data = state_r.rd_data;
    assign primary_core_lines = state_r.lines[0];
    assign secondary_core_lines = state_r.lines[1];
    assign irq = state_r.irq;

    // Checks share one clock and the reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // The peripheral mask holds exactly 26 of the 32 lines.
    a_periph_count: assert property ($countones(PERIPH) == 26)
        else $error("peripheral line count is not 26");

    // Internal lines never rise on either core.
    a_internal_quiet: assert property (
        ((primary_core_lines | secondary_core_lines) & ~PERIPH) == 0)
        else $error("internal line driven");

    // Any set line on the primary core has a source routed to it.
    a_line_has_src: assert property (
        clk_en |=> ((primary_core_lines & ~$past(raw_lines[0])) == 0))
        else $error("line high with no routed source");

    // A routed, asserted source raises its line one cycle later.
    for (genvar c = 0; c < 2; c++)
    begin : g_core_chk
        for (genvar s = 0; s < NUM_SRC; s++)
        begin : g_src_chk
            a_route_drive: assert property (
                (clk_en && src_level[s] && PERIPH[state_r.route[c][s]] &&
                (state_r.route[c][s] != `DCIRM_NMI_LINE || !nmi_mask[c]))
                |=> state_r.lines[c][$past(state_r.route[c][s])])
                else $error("routed source did not raise its line");
        end
        // The NMI line stays low while the mask input is high.
        a_nmi_blocked: assert property (
            clk_en && nmi_mask[c] |=> !state_r.lines[c][`DCIRM_NMI_LINE])
            else $error("NMI line high while masked");
    end

    // A status word read returns the source levels of that cycle.
    a_status_read: assert property (
        clk_en && bus_req.rd && bus_req.addr == `DCIRM_PRI_STAT_BASE
        |=> rd_data[0] == $past(src_level[0]))
        else $error("status bit does not match source");

    // Reading secondary status words leaves the routes unchanged.
    a_status_quiet: assert property (
        clk_en && bus_req.rd && !bus_req.wr &&
        word_hit(bus_req.addr, `DCIRM_SEC_STAT_BASE, `DCIRM_STAT_WORDS)
        |=> state_r.route == $past(state_r.route))
        else $error("status read disturbed routes");

    // Route reads show zero above the 5-bit field.
    a_route_upper: assert property (
        clk_en && bus_req.rd &&
        word_hit(bus_req.addr, `DCIRM_PRI_ROUTE_BASE, NUM_SRC)
        |=> rd_data[31:5] == 27'h0)
        else $error("route upper bits not zero");

    // Line 19 reads as level at priority 2, line 14 as NMI.
    a_line_prio: assert property (
        clk_en && bus_req.rd &&
        bus_req.addr == `DCIRM_LINE_INFO_BASE + 12'h04C
        |=> rd_data[4:0] == 5'h0A)
        else $error("line 19 info wrong");
    a_line_nmi: assert property (
        clk_en && bus_req.rd &&
        bus_req.addr == `DCIRM_LINE_INFO_BASE + 12'h038
        |=> rd_data[4:0] == 5'h1F)
        else $error("line 14 info wrong");

    // The interrupt follows the masked event bits.
    a_irq_level: assert property (
        irq == |(state_r.evt & state_r.evt_mask))
        else $error("irq disagrees with events");

    // Main scenarios.
    c_shared_line: cover property (clk_en && src_level[0] && src_level[1] &&
        state_r.route[0][0] == state_r.route[0][1] &&
        PERIPH[state_r.route[0][0]]);
    c_nmi_block: cover property (state_r.evt[`DCIRM_EVT_PRI_NMI_BLOCK]);
    c_irq_up: cover property (irq);
    c_both_cores: cover property (primary_core_lines[0] &&
        secondary_core_lines[0]);

endmodule : dcirm_matrix
`default_nettype wire

// ---- hw/dcirm_params.svh ----
`ifndef DCIRM_PARAMS_SVH
`define DCIRM_PARAMS_SVH

// Number of peripheral sources and routing field width.
`define DCIRM_NUM_SRC 69
`define DCIRM_ROUTE_W 5
`define DCIRM_STAT_WORDS 3

// Lines that peripheral sources may drive; all others are core-internal.
`define DCIRM_PERIPH_MASK 32'hDFFE_773F
// Line that carries the non-maskable interrupt.
`define DCIRM_NMI_LINE 5'h0E
// Routing value after reset: an internal line, so sources start detached.
`define DCIRM_ROUTE_RST 5'h06

// Register map, byte addresses.
`define DCIRM_PRI_ROUTE_BASE 12'h000
`define DCIRM_SEC_ROUTE_BASE 12'h200
`define DCIRM_PRI_STAT_BASE 12'h400
`define DCIRM_SEC_STAT_BASE 12'h410
`define DCIRM_EVT_STAT_ADDR 12'h420
`define DCIRM_EVT_MASK_ADDR 12'h424
`define DCIRM_LINE_INFO_BASE 12'h500

// Event bit positions in the event status and mask registers.
`define DCIRM_EVT_W 4
`define DCIRM_EVT_PRI_NMI_RISE 0
`define DCIRM_EVT_SEC_NMI_RISE 1
`define DCIRM_EVT_PRI_NMI_BLOCK 2
`define DCIRM_EVT_SEC_NMI_BLOCK 3
`define DCIRM_EVT_MASK_RST 4'h0

`endif

// ---- hw/dcirm_pkg.sv ----
`default_nettype none
package dcirm_pkg;

    // One register bus request: address, write data and the two strobes.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dcirm_bus_req_type;

    // Kind of a core interrupt line.
    typedef enum logic [1:0] {
        DCIRM_LINE_INTERNAL,
        DCIRM_LINE_LEVEL,
        DCIRM_LINE_EDGE,
        DCIRM_LINE_NMI
    } dcirm_line_kind_type;

    // Description of one core line as software reads it.
    typedef struct packed {
        dcirm_line_kind_type kind;
        logic [2:0] prio;
    } dcirm_line_info_type;

    // Returns kind and priority of a core line; NMI reads priority 7.
    function automatic dcirm_line_info_type dcirm_line_info(
        input logic [4:0] num
    );
        dcirm_line_info_type info;
        info.kind = DCIRM_LINE_LEVEL;
        info.prio = 3'h1;
        case (num)
            5'h06, 5'h07:
            begin
                info.kind = DCIRM_LINE_INTERNAL;
            end
            5'h0B, 5'h0F, 5'h1D:
            begin
                info.kind = DCIRM_LINE_INTERNAL;
                info.prio = 3'h3;
            end
            5'h10:
            begin
                info.kind = DCIRM_LINE_INTERNAL;
                info.prio = 3'h5;
            end
            5'h0A: info.kind = DCIRM_LINE_EDGE;
            5'h16:
            begin
                info.kind = DCIRM_LINE_EDGE;
                info.prio = 3'h3;
            end
            5'h1C, 5'h1E:
            begin
                info.kind = DCIRM_LINE_EDGE;
                info.prio = 3'h4;
            end
            5'h0E:
            begin
                info.kind = DCIRM_LINE_NMI;
                info.prio = 3'h7;
            end
            5'h13, 5'h14, 5'h15: info.prio = 3'h2;
            5'h17, 5'h1B: info.prio = 3'h3;
            5'h18, 5'h19: info.prio = 3'h4;
            5'h1A, 5'h1F: info.prio = 3'h5;
            default: info.prio = 3'h1;
        endcase
        return info;
    endfunction : dcirm_line_info

endpackage : dcirm_pkg
`default_nettype wire

// ---- verification/dcirm_src_model.sv ----
`default_nettype none
// Stands for the peripheral sources and the process-context controller.
// It presents new levels only after a chosen delay, so that the matrix
// sees both prompt and slow changes at its inputs.
module dcirm_src_model #(
    parameter int NUM_SRC = 69
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Levels requested by the bench and the answer delay in cycles.
    input wire logic [NUM_SRC-1:0] want_src,
    input wire logic [1:0] want_mask,
    input wire logic [1:0] lag,
    // Levels presented to the matrix.
    output logic [NUM_SRC-1:0] src_level,
    output logic [1:0] nmi_mask,
    output logic settled
);
    timeunit 1ns;
    timeprecision 1ps;

    // Counts the cycles a pending change has waited.
    logic [1:0] wait_r;

    // The model is settled once it shows what was requested.
    assign settled = ({want_src, want_mask} == {src_level, nmi_mask});

    // Applies a pending change once the delay has run out.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_level <= '0;
            nmi_mask <= 2'h0;
            wait_r <= 2'h0;
        end
        else if (!settled && wait_r >= lag)
        begin
            // The mask input blocks the core's non-maskable line.
            src_level <= want_src;
            nmi_mask <= want_mask;
            wait_r <= 2'h0;
        end
        else if (!settled)
        begin
            wait_r <= wait_r + 2'h1;
        end
        else
        begin
            wait_r <= 2'h0;
        end
    end
endmodule : dcirm_src_model
`default_nettype wire

// ---- verification/testbench.sv ----
`include "dcirm_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcirm_pkg::*;

    // Clock, reset and clock enable.
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    // Register bus request and read data.
    dcirm_bus_req_type req = '0;
    logic [31:0] rd_data;
    // Levels requested from the source model and its delay.
    logic [68:0] want_src = '0;
    logic [1:0] want_mask = 2'h0;
    logic [1:0] lag = 2'h0;
    // Levels presented by the model.
    logic [68:0] src_level;
    logic [1:0] nmi_mask;
    logic settled;
    // Outputs of the matrix.
    logic [31:0] pri_lines;
    logic [31:0] sec_lines;
    logic irq;
    // Bench copy of the routing registers, one row per core.
    logic [4:0] route_m [2][69];
    // Scratch values of the main sequence.
    logic [31:0] held;
    int c;
    int n;
    logic [4:0] v;
    // Counters of mismatches and comparisons.
    int err_count = 0;
    int cmp_count = 0;

    always #20 clock = ~clock;

    dcirm_src_model #(.NUM_SRC(69)) u_src (.clock(clock), .arst_n(arst_n),
        .want_src(want_src), .want_mask(want_mask), .lag(lag),
        .src_level(src_level), .nmi_mask(nmi_mask), .settled(settled));

    dcirm_matrix #(.NUM_SRC(69)) u_dut (.clock(clock), .arst_n(arst_n),
        .clk_en(clk_en), .bus_req(req), .rd_data(rd_data),
        .src_level(src_level), .nmi_mask(nmi_mask),
        .primary_core_lines(pri_lines), .secondary_core_lines(sec_lines),
        .irq(irq));

    // Line numbers that no peripheral source may drive.
    function automatic bit is_internal(input logic [4:0] l);
        return l inside {5'h06, 5'h07, 5'h0B, 5'h0F, 5'h10, 5'h1D};
    endfunction : is_internal

    // Lines a core should see for the requested sources and masks.
    function automatic logic [31:0] exp_lines(input int k);
        logic [31:0] l;
        l = 32'h0000_0000;
        for (int s = 0; s < 69; s++)
        begin
            if (want_src[s] && !is_internal(route_m[k][s]) &&
                !(route_m[k][s] == 5'h0E && want_mask[k]))
            begin
                l[route_m[k][s]] = 1'b1;
            end
        end
        return l;
    endfunction : exp_lines

    // Kind in bits 4:3 and priority in bits 2:0 of one core line.
    function automatic logic [4:0] exp_info(input int k);
        logic [1:0] kd;
        logic [2:0] p;
        kd = 2'h1;
        p = 3'h1;
        case (k)
            6, 7: kd = 2'h0;
            11, 15, 29: {kd, p} = {2'h0, 3'h3};
            16: {kd, p} = {2'h0, 3'h5};
            10: kd = 2'h2;
            22: {kd, p} = {2'h2, 3'h3};
            28, 30: {kd, p} = {2'h2, 3'h4};
            14: {kd, p} = {2'h3, 3'h7};
            19, 20, 21: p = 3'h2;
            23, 27: p = 3'h3;
            24, 25: p = 3'h4;
            26, 31: p = 3'h5;
            default: p = 3'h1;
        endcase
        return {kd, p};
    endfunction : exp_info

    // Byte address of a routing register.
    function automatic logic [11:0] route_addr(input int k, input int s);
        return (k == 1 ? `DCIRM_SEC_ROUTE_BASE : `DCIRM_PRI_ROUTE_BASE)
            + 12'(4 * s);
    endfunction : route_addr

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Compares one seen value with its expectation.
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One write cycle, then one idle cycle.
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock);
        req.wr <= 1'b0;
        @(posedge clock);
    endtask : bus_wr

    // One read cycle; the data are taken in the cycle after it.
    task automatic rdc(input string nm, input logic [11:0] a,
        input logic [31:0] exp);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        chk(nm, rd_data, exp);
        @(posedge clock);
    endtask : rdc

    // Writes a route with its upper bits set; they must read back zero.
    task automatic set_route(input int k, input int s, input logic [4:0] l);
        route_m[k][s] = l;
        bus_wr(route_addr(k, s), {27'h7FF_FFFF, l});
    endtask : set_route

    // Waits, bounded, for the model, then lets the matrix follow.
    task automatic check_lines();
        // Let this edge's requests land before asking the model.
        #1;
        for (int i = 0; i < 20 && !settled; i++)
            @(posedge clock);
        if (!settled)
        begin
            err_count++;
            close_out();
        end
        repeat (2) @(posedge clock);
        #1;
        chk("primary lines", pri_lines, exp_lines(0));
        chk("secondary lines", sec_lines, exp_lines(1));
        // Return on an edge, so that the next request starts there.
        @(posedge clock);
    endtask : check_lines

    // Waits, bounded, for the interrupt output to reach a level.
    task automatic wait_irq(input logic lvl);
        // Look between edges, where the output has settled.
        #1;
        for (int i = 0; i < 8 && irq !== lvl; i++)
        begin
            @(posedge clock);
            #1;
        end
        chk("irq", {31'h0, irq}, {31'h0, lvl});
        // A wait that ran out ends the run.
        if (irq !== lvl)
            close_out();
        @(posedge clock);
    endtask : wait_irq

    // Reads the status words of both cores.
    task automatic check_status();
        for (int w = 0; w < 3; w++)
        begin
            held = 32'({27'h0, want_src} >> (32 * w));
            rdc("primary status", `DCIRM_PRI_STAT_BASE + 12'(4 * w), held);
            rdc("secondary status", `DCIRM_SEC_STAT_BASE + 12'(4 * w), held);
        end
    endtask : check_status

    // Main sequence.
    initial
    begin
        void'($urandom(32'h0000_7d4a));
        foreach (route_m[k, s])
            route_m[k][s] = `DCIRM_ROUTE_RST;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rdc("route reset", route_addr(1, 68), 32'h0000_0006);
        chk("primary idle", pri_lines, 32'h0000_0000);
        for (int k = 0; k < 32; k++)
            rdc("line info", `DCIRM_LINE_INFO_BASE + 12'(4 * k),
                {27'h0, exp_info(k)});
        rdc("unmapped", 12'h114, 32'h0000_0000);
        bus_wr(12'h7F0, 32'hFFFF_FFFF);
        rdc("unmapped", 12'h7F0, 32'h0000_0000);
        // Two sources share a primary line; one also goes to the other core.
        set_route(0, 0, 5'h02);
        set_route(0, 1, 5'h02);
        set_route(1, 1, 5'h1F);
        want_src <= 69'h3;
        check_lines();
        for (int i = 0; i < 40; i++)
        begin
            c = $urandom_range(0, 1);
            n = $urandom_range(0, 68);
            v = (i % 4 == 0) ? 5'h0E : 5'($urandom_range(0, 31));
            set_route(c, n, v);
            rdc("route", route_addr(c, n), {27'h0, v});
            want_src <= 69'({$urandom(), $urandom(), $urandom()});
            want_mask <= 2'($urandom_range(0, 3));
            lag <= 2'($urandom_range(0, 3));
            check_lines();
            check_status();
        end
        // Sources in status words one and two.
        want_src <= (69'h1 << 55) | (69'h1 << 64) | (69'h1 << 66);
        check_lines();
        rdc("word one", `DCIRM_PRI_STAT_BASE + 12'h4, 32'h0080_0000);
        rdc("word two", `DCIRM_SEC_STAT_BASE + 12'h8, 32'h0000_0005);
        // A frozen matrix keeps its lines.
        held = pri_lines;
        clk_en <= 1'b0;
        want_src <= ~want_src;
        repeat (6) @(posedge clock);
        chk("frozen lines", pri_lines, held);
        clk_en <= 1'b1;
        check_lines();
        // Events of the non-maskable line and the interrupt output.
        want_src <= '0;
        want_mask <= 2'h0;
        set_route(0, 3, 5'h0E);
        // Keep the source off the other core's line 14.
        set_route(1, 3, 5'h06);
        check_lines();
        bus_wr(`DCIRM_EVT_STAT_ADDR, 32'h0000_000F);
        bus_wr(`DCIRM_EVT_MASK_ADDR, 32'h0000_0001);
        wait_irq(1'b0);
        want_src <= 69'h8;
        check_lines();
        wait_irq(1'b1);
        rdc("events", `DCIRM_EVT_STAT_ADDR, 32'h0000_0001);
        bus_wr(`DCIRM_EVT_STAT_ADDR, 32'h0000_0001);
        wait_irq(1'b0);
        want_mask <= 2'h1;
        check_lines();
        rdc("blocked", `DCIRM_EVT_STAT_ADDR, 32'h0000_0004);
        chk("masked irq", {31'h0, irq}, 32'h0000_0000);
        bus_wr(`DCIRM_EVT_MASK_ADDR, 32'h0000_0004);
        wait_irq(1'b1);
        close_out();
    end
endmodule : testbench
`default_nettype wire
